/* bench/isa_host_model.sv */
// Host model that drives the register port of the block
`timescale 1ns/1ns
module isa_host_model
(
   // Clock
   input wire mclk_i,
   // Register port
   input wire [7:0] reg_rdata_i,
   output reg [7:0] reg_addr_o = 8'h00,
   output reg [7:0] reg_wdata_o = 8'h00,
   output reg reg_wr_o = 1'b0,
   output reg reg_rd_o = 1'b0
);
   // ****
   // Access tasks, one strobe cycle each
   // ****
   task wr(input [7:0] a, input [7:0] v);
   begin
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_wdata_o <= v;
      reg_wr_o <= 1'b1;
      @(posedge mclk_i);
      reg_wr_o <= 1'b0;
      @(negedge mclk_i);
   end
   endtask
   // Data lands on the taking edge, so look half a cycle later
   task rd(input [7:0] a, output [7:0] v);
   begin
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge mclk_i);
      reg_rd_o <= 1'b0;
      @(negedge mclk_i);
      v = reg_rdata_i;
   end
   endtask
endmodule // isa_host_model

/* bench/isa_irq_status_asserts.sv */
// Port checker of the interrupt, status and aux output block
`timescale 1ns/1ns
module isa_irq_status_asserts
(
   // Clock and reset
   input wire mclk_i,
   input wire reset_n_i,
   // Register port
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   // Pins and configuration
   input wire pen_down_live_i,
   input wire touchscreen_wire_type_i,
   input wire [3:0] near_sensor_connection_i,
   input wire [3:0] near_shield_connection_i,
   // Outputs
   input wire irq_o,
   input wire soft_reset_o,
   input wire [15:0] near_average_value_o,
   input wire aux_pin1_oe_o,
   input wire aux_pin2_oe_o,
   input wire aux_pin3_oe_o
);
   // ****
   // Properties
   // ****
   wire rd_stat = reg_rd_i && reg_addr_i == 8'h24;
   wire wr_key = reg_wr_i && reg_addr_i == 8'h3F && reg_wdata_i == 8'hDE;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);
   chk_stat_read_clear: assert property (
      rd_stat ##2 rd_stat |=> !reg_rdata_o[6]) else $error("latch kept");
   chk_pen_live_bit: assert property (
      pen_down_live_i [*6] ##1 rd_stat |=> reg_rdata_o[2])
      else $error("pen bit low");
   chk_wo_read_zero: assert property (
      reg_rd_i && reg_addr_i == 8'h3F |=> reg_rdata_o == 8'h00)
      else $error("key reads back");
   chk_key_reset: assert property (
      wr_key |-> ##[1:3] (!irq_o && !aux_pin2_oe_o)) else $error("no reset");
   chk_key_pulse: assert property (
      wr_key |-> ##2 soft_reset_o) else $error("no reset pulse");
   chk_irq_masked: assert property (
      reg_wr_i && reg_addr_i == 8'h22 && reg_wdata_i == 8'h00
      |-> ##[1:3] !irq_o) else $error("masked request");
   chk_aux_type_off: assert property (
      touchscreen_wire_type_i [*3] |-> !aux_pin1_oe_o && !aux_pin3_oe_o)
      else $error("type ignored");
   chk_aux1_sensor: assert property (
      (near_sensor_connection_i == 4'h1) [*3] |-> !aux_pin1_oe_o)
      else $error("pin1 driven");
   chk_aux2_sensor: assert property (
      near_sensor_connection_i == 4'h2 && $past(near_sensor_connection_i)
      == 4'h2 |=> !aux_pin2_oe_o) else $error("pin2 driven");
   chk_aux3_shield: assert property (
      (near_shield_connection_i == 4'h3) [*3] |-> !aux_pin3_oe_o)
      else $error("pin3 driven");
   chk_avg_frozen: assert property (
      pen_down_live_i [*8] |=> $stable(near_average_value_o))
      else $error("average moved");
endmodule // isa_irq_status_asserts

bind isa_irq_status isa_irq_status_asserts isa_irq_status_asserts_inst (
   .mclk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .reg_rdata_o, .pen_down_live_i, .touchscreen_wire_type_i,
   .near_sensor_connection_i, .near_shield_connection_i, .irq_o,
   .near_average_value_o, .aux_pin1_oe_o, .aux_pin2_oe_o, .aux_pin3_oe_o,
   .soft_reset_o);

/* bench/isa_irq_status_tb.sv */
// Self-checking bench of the interrupt, status and aux output block
`timescale 1ns/1ns
module isa_irq_status_tb;
   // ****
   // Stimulus and observation
   // ****
   reg mclk = 1'b0;
   reg reset_n = 1'b0;
   reg [7:0] live = 8'h00;
   // Near conversion, near select, warn edge, alarm edge, pen mode
   reg [4:0] mode = 5'h00;
   reg [15:0] avg = 16'h1234;
   reg ts_type = 1'b0;
   reg [3:0] sens = 4'h0;
   reg [3:0] shld = 4'h0;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd, irq, trig, srst;
   wire [15:0] avg_q;
   wire [2:0] pin, oe;
   reg [7:0] d;
   integer i;
   integer miscompares = 0;
   integer compares = 0;
   // Pin 3 per select code: sources 0x88 low, status 0x84 high
   localparam [15:0] pin3_exp = 16'h8488;
   always #4 mclk = ~mclk;
   isa_host_model isa_host_model_inst (.mclk_i(mclk), .reg_rdata_i(rdata),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
   isa_irq_status isa_irq_status_inst (.mclk_i(mclk), .reset_n_i(reset_n),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .haptic_short_live_i(live[7]),
      .object_near_raw_i(live[5]), .compensation_pending_i(live[4]),
      .conversion_running_i(live[3]), .conversion_is_near_i(mode[4]),
      .pen_down_live_i(live[2]), .thermal_warn_live_i(live[1]),
      .thermal_alarm_live_i(live[0]), .near_average_raw_i(avg),
      .near_irq_event_select_i(mode[3]), .thermal_warn_edge_select_i(mode[2]),
      .thermal_alarm_edge_select_i(mode[1]),
      .pen_detect_operating_mode_i(mode[0]), .touchscreen_wire_type_i(ts_type),
      .near_sensor_connection_i(sens), .near_shield_connection_i(shld),
      .irq_o(irq), .compensation_trigger_o(trig), .soft_reset_o(srst),
      .near_average_value_o(avg_q), .aux_pin1_o(pin[0]), .aux_pin2_o(pin[1]),
      .aux_pin3_o(pin[2]), .aux_pin1_oe_o(oe[0]), .aux_pin2_oe_o(oe[1]),
      .aux_pin3_oe_o(oe[2]));
   task chk(input [7:0] s, input [7:0] e);
   begin
      compares = compares + 1;
      if (s !== e)
      begin
         miscompares = miscompares + 1;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   end
   endtask
   task rc(input [7:0] a, input [7:0] e);
   begin
      isa_host_model_inst.rd(a, d);
      chk(d, e);
   end
   endtask
   task w(input [7:0] a, input [7:0] v);
   begin
      isa_host_model_inst.wr(a, v);
   end
   endtask
   // Eight cycles covers the synchronisers, source and request stages
   task step(input [7:0] v, input [4:0] m);
   begin
      @(posedge mclk);
      live <= v;
      mode <= m;
      repeat (8) @(negedge mclk);
   end
   endtask
   task ax(input t, input [3:0] s, input [3:0] h, input [7:0] e);
   begin
      @(posedge mclk);
      ts_type <= t;
      sens <= s;
      shld <= h;
      repeat (3) @(negedge mclk);
      chk({2'b00, oe, pin}, e);
   end
   endtask
   task tally_and_finish;
   begin
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   // ****
   // Sequence
   // ****
   initial
   begin
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      rc(8'h22, 8'h08);
      rc(8'h24, 8'h40);
      rc(8'h24, 8'h00);
      rc(8'h23, 8'h00);
      rc(8'h25, 8'h00);
      rc(8'h26, 8'h00);
      rc(8'h3F, 8'h00);
      step(8'hA0, 5'h07);
      rc(8'h24, 8'hA0);
      rc(8'h23, 8'hC0);
      step(8'hBF, 5'h07);
      chk(irq, 8'h01);
      rc(8'h24, 8'hBF);
      rc(8'h23, 8'h0B);
      @(posedge mclk);
      avg <= 16'h5678;
      step(8'h84, 5'h07);
      chk(avg_q[15:8], 8'h12);
      rc(8'h24, 8'hA4);
      rc(8'h23, 8'h10);
      step(8'h00, 5'h07);
      chk(avg_q[15:8], 8'h56);
      rc(8'h24, 8'h00);
      rc(8'h23, 8'h24);
      step(8'h0B, 5'h18);
      rc(8'h23, 8'h00);
      step(8'h00, 5'h18);
      rc(8'h23, 8'h23);
      step(8'h08, 5'h08);
      step(8'h00, 5'h08);
      chk(irq, 8'h01);
      w(8'h22, 8'h00);
      repeat (2) @(negedge mclk);
      chk(irq, 8'h00);
      w(8'h23, 8'hFF);
      rc(8'h23, 8'h08);
      w(8'h22, 8'hFF);
      rc(8'h22, 8'hFF);
      w(8'h24, 8'h10);
      // Trigger output follows the request register one edge later
      @(negedge mclk);
      chk(trig, 8'h01);
      rc(8'h24, 8'h10);
      step(8'h10, 5'h01);
      step(8'h00, 5'h01);
      chk(trig, 8'h00);
      rc(8'h23, 8'h10);
      step(8'h84, 5'h01);
      w(8'h25, 8'h7A);
      w(8'h26, 8'h3F);
      ax(1'b0, 4'h0, 4'h0, 8'h3F);
      ax(1'b1, 4'h0, 4'h0, 8'h12);
      ax(1'b0, 4'h1, 4'h3, 8'h12);
      ax(1'b0, 4'h2, 4'h0, 8'h2D);
      ax(1'b0, 4'h0, 4'h0, 8'h3F);
      for (i = 0; i < 16; i = i + 1)
      begin
         w(8'h26, {4'h3, i[3:0]});
         repeat (2) @(negedge mclk);
         chk({7'h00, pin[2]}, {7'h00, pin3_exp[i]});
      end
      step(8'h00, 5'h01);
      w(8'h3F, 8'h55);
      // Only the right key would pulse the reset output here
      @(negedge mclk);
      chk(srst, 8'h00);
      rc(8'h22, 8'hFF);
      chk(irq, 8'h01);
      w(8'h3F, 8'hDE);
      @(negedge mclk);
      chk(srst, 8'h01);
      repeat (3) @(negedge mclk);
      rc(8'h22, 8'h08);
      rc(8'h26, 8'h00);
      rc(8'h24, 8'h40);
      tally_and_finish;
   end
   // A hang is cut short well past the expected run length
   initial
   begin
      repeat (5000) @(posedge mclk);
      miscompares = miscompares + 1;
      tally_and_finish;
   end
endmodule // isa_irq_status_tb

/* logic/isa_aux_mux.v */
// Signal selector for one auxiliary output pin
`timescale 1ns/1ns
module isa_aux_mux
#(
   parameter HIGH_CODES = 1
)
(
   // Sources
   input wire [7:0] src_i,
   input wire [7:0] stat_i,
   // Selection
   input wire [3:0] sel_i,
   // Result
   output reg out_o
);
`include "isa_consts.vh"
always @*
begin
   out_o = 1'b0;
   if (!sel_i[3])
      out_o = src_i[sel_i[2:0]];
   else
   begin
      case (sel_i)
         `ISA_SEL_STAT2: out_o = stat_i[`ISA_ST_PEN];
         `ISA_SEL_STAT3: out_o = stat_i[`ISA_ST_CONV];
         `ISA_SEL_STAT5: out_o = (HIGH_CODES != 0) &&
                                 stat_i[`ISA_ST_NEAR];
         `ISA_SEL_STAT6: out_o = (HIGH_CODES != 0) &&
                                 stat_i[`ISA_ST_RESET];
         `ISA_SEL_STAT7: out_o = (HIGH_CODES != 0) &&
                                 stat_i[`ISA_ST_HAPT];
         // Reserved codes drive low
         default: out_o = 1'b0;
      endcase
   end
end
endmodule // isa_aux_mux

/* logic/isa_consts.vh */
// Constants for the interrupt, status and auxiliary output block
`ifndef ISA_CONSTS_VH
`define ISA_CONSTS_VH
// Register addresses
`define ISA_ADDR_IRQ_EN 8'h22
`define ISA_ADDR_IRQ_SRC 8'h23
`define ISA_ADDR_STATUS 8'h24
`define ISA_ADDR_AUX_A 8'h25
`define ISA_ADDR_AUX_B 8'h26
`define ISA_ADDR_SWRST 8'h3F
// Reset values and software reset key
`define ISA_IRQ_EN_RST 8'h08
`define ISA_ZERO8 8'h00
`define ISA_RESET_KEY 8'hDE
// Status bit positions
`define ISA_ST_HAPT 7
`define ISA_ST_RESET 6
`define ISA_ST_NEAR 5
`define ISA_ST_COMP 4
`define ISA_ST_CONV 3
`define ISA_ST_PEN 2
`define ISA_ST_WARN 1
`define ISA_ST_ALARM 0
// Source bit positions
`define ISA_SRC_HAPT 7
`define ISA_SRC_NEAR 6
`define ISA_SRC_GONE 5
`define ISA_SRC_COMP 4
`define ISA_SRC_PEN_DN 3
`define ISA_SRC_PEN_UP 2
`define ISA_SRC_WARN 1
`define ISA_SRC_ALARM 0
// Aux control A and B fields
`define ISA_AUX1_EN 6
`define ISA_AUX2_EN 5
`define ISA_AUX3_EN 4
`define ISA_AUX1_SEL 3:0
`define ISA_AUX2_SEL 7:4
`define ISA_AUX3_SEL 3:0
// Connection codes
`define ISA_CON_AUX1 4'h1
`define ISA_CON_AUX2 4'h2
`define ISA_CON_AUX3 4'h3
// Select decoding
`define ISA_SEL_STAT2 4'hA
`define ISA_SEL_STAT3 4'hB
`define ISA_SEL_STAT5 4'hD
`define ISA_SEL_STAT6 4'hE
`define ISA_SEL_STAT7 4'hF
`endif

/* logic/isa_irq_status.v */
// Interrupt source, status and auxiliary output logic
`timescale 1ns/1ns
module isa_irq_status
(
   // Clock and reset
   input wire mclk_i,
   input wire reset_n_i,
   // Register port
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   // Live status pins from the engines
   input wire haptic_short_live_i,
   input wire object_near_raw_i,
   input wire compensation_pending_i,
   input wire conversion_running_i,
   input wire conversion_is_near_i,
   input wire pen_down_live_i,
   input wire thermal_warn_live_i,
   input wire thermal_alarm_live_i,
   input wire [15:0] near_average_raw_i,
   // Configuration from other registers
   input wire near_irq_event_select_i,
   input wire thermal_warn_edge_select_i,
   input wire thermal_alarm_edge_select_i,
   input wire pen_detect_operating_mode_i,
   input wire touchscreen_wire_type_i,
   input wire [3:0] near_sensor_connection_i,
   input wire [3:0] near_shield_connection_i,
   // Outputs
   output reg irq_o,
   output reg compensation_trigger_o,
   output reg soft_reset_o,
   output reg [15:0] near_average_value_o,
   output reg aux_pin1_o,
   output reg aux_pin2_o,
   output reg aux_pin3_o,
   output reg aux_pin1_oe_o,
   output reg aux_pin2_oe_o,
   output reg aux_pin3_oe_o
);
`include "isa_consts.vh"

// ****************************************
// Reset combining and input synchronisers
// ****************************************
localparam NSYNC = 8;
reg soft_rst_r;
// Key write resets all but the key register itself
wire rst_n = reset_n_i & ~soft_rst_r;
wire [NSYNC-1:0] raw_in;
reg [NSYNC-1:0] s1_r;
reg [NSYNC-1:0] s2_r;
reg [NSYNC-1:0] s3_r;
reg [NSYNC-1:0] live_r;
reg [NSYNC-1:0] prev_r;
assign raw_in = {haptic_short_live_i, object_near_raw_i,
                 compensation_pending_i, conversion_running_i,
                 pen_down_live_i, thermal_warn_live_i,
                 thermal_alarm_live_i, conversion_is_near_i};
localparam I_HAPT = 7;
localparam I_NEAR = 6;
localparam I_COMP = 5;
localparam I_CONV = 4;
localparam I_PEN = 3;
localparam I_WARN = 2;
localparam I_ALARM = 1;
localparam I_KIND = 0;

// Three stages; a change is accepted when stages two and three agree
genvar g;
generate
   for (g = 0; g < NSYNC; g = g + 1)
   begin : g_sync
      always @(posedge mclk_i or negedge rst_n)
      begin
         if (!rst_n)
         begin
            s1_r[g] <= 1'b0;
            s2_r[g] <= 1'b0;
            s3_r[g] <= 1'b0;
            live_r[g] <= 1'b0;
            prev_r[g] <= 1'b0;
         end
         else
         begin
            s1_r[g] <= raw_in[g];
            s2_r[g] <= s1_r[g];
            s3_r[g] <= s2_r[g];
            if (s2_r[g] == s3_r[g])
               live_r[g] <= s3_r[g];
            prev_r[g] <= live_r[g];
         end
      end
   end
endgenerate

// ****************************************
// Near status freeze
// ****************************************
reg near_held_r;
reg [15:0] avg_s1_r;
reg [15:0] avg_s2_r;
wire pen_now = live_r[I_PEN];
// Multi-bit average is sampled twice; only copied while pen is up
always @(posedge mclk_i or negedge rst_n)
begin
   if (!rst_n)
   begin
      near_held_r <= 1'b0;
      avg_s1_r <= 16'h0000;
      avg_s2_r <= 16'h0000;
      near_average_value_o <= 16'h0000;
   end
   else
   begin
      avg_s1_r <= near_average_raw_i;
      avg_s2_r <= avg_s1_r;
      if (!pen_now)
      begin
         near_held_r <= live_r[I_NEAR];
         near_average_value_o <= avg_s2_r;
      end
   end
end
reg near_prev_r;

// ****************************************
// Edge detection
// ****************************************
wire rise_hapt = live_r[I_HAPT] & ~prev_r[I_HAPT];
// Near edges use the held copy, so a frozen status raises no event
wire rise_near = near_held_r & ~near_prev_r;
wire fall_near = ~near_held_r & near_prev_r;
wire fall_comp = ~live_r[I_COMP] & prev_r[I_COMP];
wire fall_conv = ~live_r[I_CONV] & prev_r[I_CONV];
wire rise_pen = live_r[I_PEN] & ~prev_r[I_PEN];
wire fall_pen = ~live_r[I_PEN] & prev_r[I_PEN];
wire chg_warn = live_r[I_WARN] ^ prev_r[I_WARN];
wire chg_alarm = live_r[I_ALARM] ^ prev_r[I_ALARM];
// Conversion kind is read from the delayed copy, valid at the fall
wire conv_near = prev_r[I_KIND];
reg [7:0] ev;
always @*
begin
   ev = 8'h00;
   ev[`ISA_SRC_HAPT] = rise_hapt;
   ev[`ISA_SRC_NEAR] = rise_near;
   ev[`ISA_SRC_GONE] = near_irq_event_select_i ?
                       (fall_conv & conv_near) : fall_near;
   ev[`ISA_SRC_COMP] = fall_comp;
   ev[`ISA_SRC_PEN_DN] = pen_detect_operating_mode_i ? rise_pen :
                         (fall_conv & ~conv_near);
   ev[`ISA_SRC_PEN_UP] = fall_pen;
   ev[`ISA_SRC_WARN] = chg_warn & (live_r[I_WARN] ==
                       thermal_warn_edge_select_i);
   ev[`ISA_SRC_ALARM] = chg_alarm & (live_r[I_ALARM] ==
                        thermal_alarm_edge_select_i);
end

// ****************************************
// Registers
// ****************************************
reg [7:0] irq_en_r;
reg [7:0] irq_src_r;
reg [7:0] aux_a_r;
reg [7:0] aux_b_r;
reg reset_seen_r;
reg comp_req_r;
wire wr_en = reg_wr_i && (reg_addr_i == `ISA_ADDR_IRQ_EN);
wire rd_src = reg_rd_i && (reg_addr_i == `ISA_ADDR_IRQ_SRC);
wire rd_stat = reg_rd_i && (reg_addr_i == `ISA_ADDR_STATUS);
wire wr_stat = reg_wr_i && (reg_addr_i == `ISA_ADDR_STATUS);
wire wr_swrst = reg_wr_i && (reg_addr_i == `ISA_ADDR_SWRST);
wire [7:0] status;
assign status = {live_r[I_HAPT], reset_seen_r, near_held_r,
                 live_r[I_COMP] | comp_req_r, live_r[I_CONV],
                 live_r[I_PEN], live_r[I_WARN],
                 live_r[I_ALARM]};

always @(posedge mclk_i or negedge rst_n)
begin
   if (!rst_n)
   begin
      irq_en_r <= `ISA_IRQ_EN_RST;
      irq_src_r <= `ISA_ZERO8;
      aux_a_r <= `ISA_ZERO8;
      aux_b_r <= `ISA_ZERO8;
      reset_seen_r <= 1'b1;
      comp_req_r <= 1'b0;
      near_prev_r <= 1'b0;
   end
   else
   begin
      near_prev_r <= near_held_r;
      if (wr_en)
         irq_en_r <= reg_wdata_i;
      if (reg_wr_i && (reg_addr_i == `ISA_ADDR_AUX_A))
         aux_a_r <= reg_wdata_i;
      if (reg_wr_i && (reg_addr_i == `ISA_ADDR_AUX_B))
         aux_b_r <= reg_wdata_i;
      // Source read clears; a new event in the same cycle survives
      irq_src_r <= (rd_src ? `ISA_ZERO8 : irq_src_r) | ev;
      if (rd_stat)
         reset_seen_r <= 1'b0;
      // Request holds until the engine reports pending
      if (wr_stat && reg_wdata_i[`ISA_ST_COMP])
         comp_req_r <= 1'b1;
      else if (live_r[I_COMP])
         comp_req_r <= 1'b0;
   end
end

// ****************************************
// Software reset key
// ****************************************
// Runs on the pin reset only, so the internal pulse lasts a full
// cycle instead of clearing itself within the same instant
always @(posedge mclk_i or negedge reset_n_i)
begin
   if (!reset_n_i)
   begin
      soft_rst_r <= 1'b0;
      soft_reset_o <= 1'b0;
   end
   else
   begin
      soft_rst_r <= wr_swrst &&
                    (reg_wdata_i == `ISA_RESET_KEY);
      // Visible to the rest of the chip one cycle after the internal reset is applied
      soft_reset_o <= soft_rst_r;
   end
end

// ****************************************
// Auxiliary output selection
// ****************************************
wire aux1_val;
wire aux2_val;
wire aux3_val;
isa_aux_mux #(.HIGH_CODES(0)) u_aux1
(
   .src_i(irq_src_r),
   .stat_i(status),
   .sel_i(aux_a_r[`ISA_AUX1_SEL]),
   .out_o(aux1_val)
);
isa_aux_mux #(.HIGH_CODES(0)) u_aux2
(
   .src_i(irq_src_r),
   .stat_i(status),
   .sel_i(aux_b_r[`ISA_AUX2_SEL]),
   .out_o(aux2_val)
);
isa_aux_mux #(.HIGH_CODES(1)) u_aux3
(
   .src_i(irq_src_r),
   .stat_i(status),
   .sel_i(aux_b_r[`ISA_AUX3_SEL]),
   .out_o(aux3_val)
);
// Pins 1 and 2 never drive while the sensor owns them, pin 3 while the shield does
wire aux1_ok = aux_a_r[`ISA_AUX1_EN] && !touchscreen_wire_type_i &&
   (near_sensor_connection_i != `ISA_CON_AUX1);
wire aux2_ok = aux_a_r[`ISA_AUX2_EN] &&
   (near_sensor_connection_i != `ISA_CON_AUX2);
wire aux3_ok = aux_a_r[`ISA_AUX3_EN] && !touchscreen_wire_type_i &&
   (near_shield_connection_i != `ISA_CON_AUX3);

// ****************************************
// Read data and output registers
// ****************************************
reg [7:0] rdata_nxt;
always @*
begin
   case (reg_addr_i)
      `ISA_ADDR_IRQ_EN: rdata_nxt = irq_en_r;
      `ISA_ADDR_IRQ_SRC: rdata_nxt = irq_src_r;
      `ISA_ADDR_STATUS: rdata_nxt = status;
      `ISA_ADDR_AUX_A: rdata_nxt = aux_a_r;
      `ISA_ADDR_AUX_B: rdata_nxt = aux_b_r;
      // Reset key register is write only
      default: rdata_nxt = `ISA_ZERO8;
   endcase
end

always @(posedge mclk_i or negedge rst_n)
begin
   if (!rst_n)
   begin
      reg_rdata_o <= `ISA_ZERO8;
      irq_o <= 1'b0;
      compensation_trigger_o <= 1'b0;
      aux_pin1_o <= 1'b0;
      aux_pin2_o <= 1'b0;
      aux_pin3_o <= 1'b0;
      aux_pin1_oe_o <= 1'b0;
      aux_pin2_oe_o <= 1'b0;
      aux_pin3_oe_o <= 1'b0;
   end
   else
   begin
      if (reg_rd_i)
         reg_rdata_o <= rdata_nxt;
      irq_o <= |(irq_src_r & irq_en_r);
      compensation_trigger_o <= comp_req_r;
      // Value forced low whenever its pin is not driven
      aux_pin1_o <= aux1_val & aux1_ok;
      aux_pin2_o <= aux2_val & aux2_ok;
      aux_pin3_o <= aux3_val & aux3_ok;
      aux_pin1_oe_o <= aux1_ok;
      aux_pin2_oe_o <= aux2_ok;
      aux_pin3_oe_o <= aux3_ok;
   end
end
endmodule // isa_irq_status
